// ===== sif_pkg.sv
// package for the supply integrity reset and flag block
// ----------------------------------------------------------------------------
// Overview of operation
// [RULE_01] supply below brownout threshold holds core reset and drives reset pin low
// [RULE_02] watchdog underflow drives reset pin low for at least minimum pulse width
// [RULE_03] brownout threshold chosen low, medium or high by option setting
// [RULE_04] brownout detector enabled by option; disabled means no brownout reset
// [RULE_05] early warning works only while brownout detector is enabled
// [RULE_06] bit 1 shows live warning comparator, read only
// [RULE_07] warning interrupt raised only when bit 0 enable set and global mask clear
// [RULE_08] pending warning interrupt clears on entry to its service routine
// [RULE_09] warning wakes from wait not halt; detector stays active in halt
// [RULE_10] bit 4 watchdog cause set on watchdog reset, cleared by zero write or brownout
// [RULE_11] bit 2 brownout cause set on brownout reset, cleared by register read
// [RULE_12] brownout cause survives pin and watchdog resets
// [RULE_13] cause code: 00 pin, watchdog only, brownout with watchdog don't care
// [RULE_14] bit 3 shows pll lock, software cannot change it
// [RULE_15] bits 7 to 5 read zero; software writes zero
// [RULE_16] after reset bits 7 to 3 and bit 0 read zero; bit 4 here is not cleared by reset and keeps its value
// [RULE_17] brownout cause value unspecified while detector disabled
// [RULE_18] comparator inputs synchronised before use
// ----------------------------------------------------------------------------
package sif_pkg;
    // register map
    localparam logic [1:0] ADDR_CSR = 2'h0;
    localparam logic [1:0] ADDR_IRQ_STAT = 2'h1;
    localparam logic [1:0] ADDR_IRQ_MASK = 2'h2;
    // control/status bit positions
    localparam int BIT_WARN_IE = 0;
    localparam int BIT_WARN_F = 1;
    localparam int BIT_BO_RF = 2;
    localparam int BIT_LOCK = 3;
    localparam int BIT_DOG_RF = 4;
    localparam logic [7:0] CSR_RESET = 8'h00;
    // event status bits
    localparam int EV_WARN_RISE = 0;
    localparam int EV_BROWNOUT = 1;
    localparam int EV_DOG = 2;
    localparam int EV_WIDTH = 3;
    // brownout level select codes
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MED = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    // timing
    localparam int CLK_MHZ = 100;
    localparam int RST_OUT_MIN_NS = 1000;
    localparam int RST_OUT_CYC = (RST_OUT_MIN_NS * CLK_MHZ + 999) / 1000;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sif_bus_type;

    typedef struct packed {
        logic bo_en;
        logic [1:0] bo_level;
    } sif_opt_type;
endpackage : sif_pkg

// ===== sif_top.sv
// supply integrity: brownout/watchdog reset pin, cause flags, warning irq
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
module sif_top #(
    parameter int RST_CYC = sif_pkg::RST_OUT_CYC
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire sif_pkg::sif_bus_type bus_i,
    output logic [7:0] rdata_o,
    input wire sif_pkg::sif_opt_type opt_i,
    input wire logic [2:0] bo_cmp_i,
    input wire logic warn_cmp_i,
    input wire logic pll_lock_i,
    input wire logic dog_underflow_i,
    input wire logic gmask_i,
    input wire logic isr_enter_i,
    input wire logic halt_i,
    input wire logic wait_i,
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    output logic core_rst_o,
    output logic warn_irq_o,
    output logic wake_o,
    output logic irq_o
);
    initial begin
        if (RST_CYC < 1 || RST_CYC > 65535) begin
            $error("RST_CYC out of range");
        end
    end

    // ------------------------------------------------------------------------
    // three stage input sampling
    // ------------------------------------------------------------------------
    logic [5:0] s1_q, s2_q, s3_q;
    wire [5:0] raw_w = {pll_lock_i, rst_pin_i, warn_cmp_i, bo_cmp_i};
    always_ff @(posedge core_clk_i) begin
        s1_q <= raw_w; // [RULE_18]
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
    // stable bit clears while stages 2 and 3 disagree, sets once they agree high, else holds
    logic [5:0] st_q;
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_q <= 6'h10;
        end else begin
            st_q <= (st_q & ~(s2_q ^ s3_q)) | (s2_q & ~(s2_q ^ s3_q)); // [RULE_18]
        end
    end
    wire [2:0] bo_sel_w = st_q[2:0];
    wire warn_s_w = st_q[3];
    wire pin_low_w = ~st_q[4];
    wire lock_s_w = st_q[5];

    // ------------------------------------------------------------------------
    // brownout level select and enable
    // ------------------------------------------------------------------------
    logic bo_lvl_w;
    always_comb begin
        case (opt_i.bo_level)
            sif_pkg::LVL_LOW: bo_lvl_w = bo_sel_w[0]; // [RULE_03]
            sif_pkg::LVL_MED: bo_lvl_w = bo_sel_w[1];
            sif_pkg::LVL_HIGH: bo_lvl_w = bo_sel_w[2];
            default: bo_lvl_w = bo_sel_w[2];
        endcase
    end
    // comparator has its own hysteresis, level is held reset
    wire bo_act_w = opt_i.bo_en & bo_lvl_w; // [RULE_01] [RULE_04]
    wire warn_live_w = opt_i.bo_en & warn_s_w; // [RULE_05]

    // ------------------------------------------------------------------------
    // watchdog reset pulse counter
    // ------------------------------------------------------------------------
    logic [15:0] dog_cnt_q;
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            dog_cnt_q <= 16'h0000;
        end else if (dog_underflow_i) begin
            dog_cnt_q <= 16'(RST_CYC); // [RULE_02]
        end else if (dog_cnt_q != 16'h0000) begin
            dog_cnt_q <= dog_cnt_q - 16'h0001;
        end
    end
    wire dog_act_w = dog_underflow_i | (dog_cnt_q != 16'h0000);

    // reset pin and core reset outputs
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rst_pin_o <= 1'b0;
            rst_pin_oe_o <= 1'b0;
            core_rst_o <= 1'b0;
        end else begin
            rst_pin_o <= 1'b0;
            rst_pin_oe_o <= bo_act_w | dog_act_w; // [RULE_01] [RULE_02]
            core_rst_o <= bo_act_w | dog_act_w | pin_low_w; // [RULE_01]
        end
    end

    // ------------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------------
    wire csr_wr_w = bus_i.wr && bus_i.addr == sif_pkg::ADDR_CSR;
    wire csr_rd_w = bus_i.rd && bus_i.addr == sif_pkg::ADDR_CSR;
    wire ist_wr_w = bus_i.wr && bus_i.addr == sif_pkg::ADDR_IRQ_STAT;
    wire msk_wr_w = bus_i.wr && bus_i.addr == sif_pkg::ADDR_IRQ_MASK;

    // ------------------------------------------------------------------------
    // cause flags, interrupt enable
    // ------------------------------------------------------------------------
    logic ie_q, dog_rf_q, bo_rf_q, dog_prev_q, bo_prev_q;
    wire dog_set_w = dog_underflow_i;
    wire bo_set_w = bo_act_w & ~bo_prev_q;
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ie_q <= 1'b0; // [RULE_16]
            dog_prev_q <= 1'b0;
            bo_prev_q <= 1'b0;
        end else begin
            dog_prev_q <= dog_act_w;
            bo_prev_q <= bo_act_w;
            if (csr_wr_w) begin
                ie_q <= bus_i.wdata[sif_pkg::BIT_WARN_IE];
            end
        end
    end
    // cause flags live outside the chip reset so they survive it
    always_ff @(posedge core_clk_i) begin
        if (bo_act_w) begin
            dog_rf_q <= 1'b0; // [RULE_10] [RULE_13]
        end else if (dog_set_w) begin
            dog_rf_q <= 1'b1; // [RULE_10]
        end else if (srst_i && dog_cnt_q == 16'h0000 && !dog_prev_q) begin
            dog_rf_q <= dog_rf_q;
        end else if (csr_wr_w && !bus_i.wdata[sif_pkg::BIT_DOG_RF]) begin
            dog_rf_q <= 1'b0; // [RULE_10]
        end
    end
    // brownout cause has no meaning while the detector is off [RULE_17]
    always_ff @(posedge core_clk_i) begin
        if (bo_set_w || bo_act_w) begin
            bo_rf_q <= 1'b1; // [RULE_11] [RULE_12]
        end else if (csr_rd_w && !srst_i) begin
            bo_rf_q <= 1'b0; // [RULE_11]
        end
    end

    // ------------------------------------------------------------------------
    // warning interrupt
    // ------------------------------------------------------------------------
    logic warn_prev_q, pend_q;
    wire warn_rise_w = warn_live_w & ~warn_prev_q;
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            warn_prev_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            warn_prev_q <= warn_live_w;
            if (warn_rise_w && ie_q) begin
                pend_q <= 1'b1; // [RULE_07]
            end else if (isr_enter_i || !opt_i.bo_en) begin
                pend_q <= 1'b0; // [RULE_08] [RULE_05]
            end
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            warn_irq_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            warn_irq_o <= pend_q & ~gmask_i & ~isr_enter_i; // [RULE_07]
            wake_o <= pend_q & wait_i & ~halt_i; // [RULE_09]
        end
    end

    // ------------------------------------------------------------------------
    // event status and mask
    // ------------------------------------------------------------------------
    logic [2:0] ev_q, mask_q;
    wire [2:0] ev_set_w = {dog_set_w, bo_set_w, warn_rise_w};
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ev_q <= 3'h0;
            mask_q <= 3'h0;
            irq_o <= 1'b0;
        end else begin
            // set wins over write-one-to-clear
            ev_q <= (ev_q & ~(ist_wr_w ? bus_i.wdata[2:0] : 3'h0)) | ev_set_w;
            if (msk_wr_w) begin
                mask_q <= bus_i.wdata[2:0];
            end
            irq_o <= |(ev_q & mask_q);
        end
    end

    // ------------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------------
    wire [7:0] csr_w = {3'h0, dog_rf_q, lock_s_w, bo_rf_q, warn_live_w, ie_q}; // [RULE_15]
    logic [7:0] rmux_w;
    always_comb begin
        case (bus_i.addr)
            sif_pkg::ADDR_CSR: rmux_w = csr_w; // [RULE_06] [RULE_14]
            sif_pkg::ADDR_IRQ_STAT: rmux_w = {5'h00, ev_q};
            sif_pkg::ADDR_IRQ_MASK: rmux_w = {5'h00, mask_q};
            default: rmux_w = 8'h00;
        endcase
    end
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= bus_i.rd ? rmux_w : 8'h00;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    bo_pin_low_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        bo_act_w |=> rst_pin_oe_o && core_rst_o) // [RULE_01]
        else $error("brownout did not drive reset");
    dog_pulse_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        dog_underflow_i |=> rst_pin_oe_o [*2]) // [RULE_02]
        else $error("watchdog pulse too short");
    bo_off_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !opt_i.bo_en && !dog_act_w |=> !rst_pin_oe_o) // [RULE_04]
        else $error("reset with brownout disabled");
    warn_gate_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !opt_i.bo_en |-> !warn_live_w) // [RULE_05]
        else $error("warning live while detector off");
    irq_gate_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        warn_irq_o |-> $past(pend_q) && !$past(gmask_i)) // [RULE_07]
        else $error("irq without enable");
    isr_clear_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        isr_enter_i && !(warn_rise_w && ie_q) |=> !pend_q) // [RULE_08]
        else $error("pending not cleared");
    halt_wake_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        halt_i |=> !wake_o) // [RULE_09]
        else $error("wake from halt");
    dog_flag_a: assert property (@(posedge core_clk_i)
        dog_set_w && !bo_act_w |=> dog_rf_q) // [RULE_10]
        else $error("watchdog flag not set");
    bo_flag_a: assert property (@(posedge core_clk_i)
        bo_act_w |=> bo_rf_q) // [RULE_11]
        else $error("brownout flag not set");
    reserved_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        $past(bus_i.rd) |-> rdata_o[7:5] == 3'h0) // [RULE_15]
        else $error("reserved bits nonzero");

    // ------------------------------------------------------------------------
    // further checks on pin, flags and interrupt
    // ------------------------------------------------------------------------
    // open-drain pin never driven high
    pin_zero_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        rst_pin_oe_o |-> !rst_pin_o) // [RULE_01]
        else $error("reset pin driven high");

    // pin let go once no source is active
    pin_release_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !bo_act_w && !dog_act_w |=> !rst_pin_oe_o) // [RULE_01]
        else $error("reset pin held without source");

    // pulse counter keeps the pin low
    dog_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        dog_cnt_q != 16'h0000 |=> rst_pin_oe_o) // [RULE_02]
        else $error("watchdog pulse released early");

    // underflow loads the full pulse length
    dog_load_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        dog_underflow_i |=> dog_cnt_q == 16'(RST_CYC)) // [RULE_02]
        else $error("watchdog pulse not loaded");

    // low level follows its own comparator
    lvl_low_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        opt_i.bo_en && opt_i.bo_level == sif_pkg::LVL_LOW |-> bo_act_w == bo_sel_w[0]) // [RULE_03]
        else $error("low level select wrong");

    // medium level follows its own comparator
    lvl_med_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        opt_i.bo_en && opt_i.bo_level == sif_pkg::LVL_MED |-> bo_act_w == bo_sel_w[1]) // [RULE_03]
        else $error("medium level select wrong");

    // high level follows its own comparator
    lvl_high_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        opt_i.bo_en && opt_i.bo_level == sif_pkg::LVL_HIGH |-> bo_act_w == bo_sel_w[2]) // [RULE_03]
        else $error("high level select wrong");

    // disabled detector never asks for reset
    bo_quiet_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !opt_i.bo_en |-> !bo_act_w) // [RULE_04]
        else $error("brownout active while disabled");

    // read shows the live warning level
    warn_read_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        csr_rd_w |=> rdata_o[sif_pkg::BIT_WARN_F] == $past(warn_live_w)) // [RULE_06]
        else $error("warning flag read wrong");

    // no pending request without the enable
    pend_need_ie_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !pend_q && !(warn_rise_w && ie_q) |=> !pend_q) // [RULE_07]
        else $error("pending set without enable");

    // enabled rise always pends
    pend_set_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        warn_rise_w && ie_q |=> pend_q) // [RULE_07]
        else $error("pending not set");

    // global mask blocks the request
    gmask_block_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        gmask_i |=> !warn_irq_o) // [RULE_07]
        else $error("request while globally masked");

    // service entry drops the request
    isr_drop_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        isr_enter_i |=> !warn_irq_o) // [RULE_08]
        else $error("request after service entry");

    // pending warning wakes from wait
    wait_wake_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        pend_q && wait_i && !halt_i |=> wake_o) // [RULE_09]
        else $error("no wake from wait");

    // detector stays live during halt
    halt_live_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        halt_i && opt_i.bo_en && warn_s_w |-> warn_live_w) // [RULE_09]
        else $error("warning dead in halt");

    // zero write clears the watchdog cause
    dog_clear_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        csr_wr_w && !bus_i.wdata[sif_pkg::BIT_DOG_RF] && !dog_set_w && !bo_act_w
        |=> !dog_rf_q) // [RULE_10]
        else $error("watchdog cause not cleared");

    // brownout wipes the watchdog cause
    bo_wipe_a: assert property (@(posedge core_clk_i)
        bo_act_w |=> !dog_rf_q) // [RULE_10]
        else $error("watchdog cause kept through brownout");

    // register read clears the brownout cause
    bo_read_clr_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        csr_rd_w && !bo_act_w |=> !bo_rf_q) // [RULE_11]
        else $error("brownout cause not cleared by read");

    // brownout cause survives other resets
    bo_keep_a: assert property (@(posedge core_clk_i)
        bo_rf_q && !(csr_rd_w && !srst_i) |=> bo_rf_q) // [RULE_12]
        else $error("brownout cause lost");

    // read shows the lock indicator
    lock_read_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        csr_rd_w |=> rdata_o[sif_pkg::BIT_LOCK] == $past(lock_s_w)) // [RULE_14]
        else $error("lock flag read wrong");

    // pin reset reaches the core
    pin_core_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        pin_low_w |=> core_rst_o) // [RULE_13]
        else $error("pin reset not passed on");

    // enable bit cleared by reset
    ie_reset_a: assert property (@(posedge core_clk_i)
        srst_i |=> !ie_q) // [RULE_16]
        else $error("enable not cleared by reset");

    // agreed samples become the stable value
    sync_take_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s2_q == s3_q |=> st_q == $past(s3_q)) // [RULE_18]
        else $error("synchroniser did not settle");

    // status set wins over clear
    ev_dog_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        dog_set_w |=> ev_q[sif_pkg::EV_DOG])
        else $error("watchdog event lost");

    // unmasked event raises the line
    irq_level_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        |(ev_q & mask_q) |=> irq_o)
        else $error("event interrupt missing");

    // read data idle outside a read
    rdata_idle_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !bus_i.rd |=> rdata_o == 8'h00)
        else $error("read data not idle");
endmodule : sif_top

// ===== sif_pin_model.sv
// reset pin partner: open-drain wire with pull-up and external sink
`timescale 1ns/1ps
module sif_pin_model (
    input wire logic oe_i,
    input wire logic drv_i,
    input wire logic ext_low_i,
    output logic pin_o
);
    // pull-up holds the pin high unless a party sinks it
    assign pin_o = ((oe_i && !drv_i) || ext_low_i) ? 1'b0 : 1'b1;
endmodule : sif_pin_model

// ===== supply_integrity_reset_flags_bench.sv
// self-checking bench for the supply integrity block
`timescale 1ns/1ps
module supply_integrity_reset_flags_bench;
    localparam int RC = 4;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    sif_pkg::sif_bus_type bus = '0;
    sif_pkg::sif_opt_type opt = '0;
    logic [2:0] bo_cmp = 3'h0;
    logic warn = 1'b0, lock = 1'b0, dog = 1'b0, gmask = 1'b0, isr = 1'b0;
    logic halt = 1'b0, wt = 1'b0, ext_low = 1'b0;
    logic pin, pin_o, oe, core_rst, warn_irq, wake, irq;
    logic [7:0] rdata, rv;
    int error_cnt = 0;
    int num_checks = 0;

    // ------------------------------------------------------------------
    // clock, design and pin partner
    // ------------------------------------------------------------------
    initial forever #5 core_clk_i = ~core_clk_i;
    sif_top #(.RST_CYC(RC)) dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .bus_i(bus),
        .rdata_o(rdata), .opt_i(opt), .bo_cmp_i(bo_cmp), .warn_cmp_i(warn),
        .pll_lock_i(lock), .dog_underflow_i(dog), .gmask_i(gmask), .isr_enter_i(isr),
        .halt_i(halt), .wait_i(wt), .rst_pin_i(pin), .rst_pin_o(pin_o),
        .rst_pin_oe_o(oe), .core_rst_o(core_rst), .warn_irq_o(warn_irq), .wake_o(wake),
        .irq_o(irq));
    sif_pin_model pm (.oe_i(oe), .drv_i(pin_o), .ext_low_i(ext_low), .pin_o(pin));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge core_clk_i);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        bus <= '0;
        #1 v = rdata;
    endtask : rd
    task automatic conclude();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // brownout per level, cause flags and read clear
    task automatic t_brownout();
        for (int l = 0; l < 3; l++) begin
            opt <= '{bo_en: 1'b1, bo_level: 2'(l)};
            bo_cmp <= ~(3'h1 << l);
            tk(6);
            chk(oe, 8'h00);
            bo_cmp <= 3'h1 << l;
            tk(6);
            chk({oe, core_rst, pin}, 8'h06);
            bo_cmp <= 3'h0;
            tk(6);
            chk(oe, 8'h00);
        end
        rd(2'h0, rv);
        chk(rv & 8'h14, 8'h04);
        rd(2'h0, rv);
        chk(rv & 8'h14, 8'h00);
    endtask : t_brownout
    // watchdog pulse width, cause flags, event irq
    task automatic t_dog();
        int n;
        wr(2'h2, 8'h04);
        @(posedge core_clk_i);
        dog <= 1'b1;
        @(posedge core_clk_i);
        dog <= 1'b0;
        #1 n = 0;
        chk(pin, 8'h00);
        while (oe === 1'b1 && n < 50) begin
            n++;
            tk(1);
        end
        chk(8'(n), 8'(RC + 1));
        chk(irq, 8'h01);
        wr(2'h2, 8'h00);
        tk(2);
        chk(irq, 8'h00);
        wr(2'h2, 8'h04);
        wr(2'h1, 8'h04);
        tk(2);
        chk(irq, 8'h00);
        rd(2'h0, rv);
        chk(rv & 8'h14, 8'h10);
        wr(2'h0, 8'h00);
        rd(2'h0, rv);
        chk(rv & 8'h14, 8'h00);
        bo_cmp <= 3'h7;
        tk(6);
        bo_cmp <= 3'h0;
        ext_low <= 1'b1;
        tk(6);
        chk({oe, core_rst}, 8'h01);
        ext_low <= 1'b0;
        dog <= 1'b1;
        tk(1);
        dog <= 1'b0;
        tk(RC + 8);
        rd(2'h0, rv);
        chk(rv & 8'h04, 8'h04);
        rd(2'h3, rv);
        chk(rv, 8'h00);
    endtask : t_dog
    // warning flag, irq enable, mask, service entry, wake, disable
    task automatic t_warn();
        lock <= 1'b1;
        halt <= 1'b1;
        tk(4);
        wr(2'h0, 8'h03);
        rd(2'h0, rv);
        chk(rv & 8'hEB, 8'h09);
        gmask <= 1'b1;
        warn <= 1'b1;
        tk(6);
        chk({warn_irq, wake}, 8'h00);
        rd(2'h0, rv);
        chk(rv & 8'h02, 8'h02);
        gmask <= 1'b0;
        halt <= 1'b0;
        wt <= 1'b1;
        tk(3);
        chk({warn_irq, wake}, 8'h03);
        isr <= 1'b1;
        tk(1);
        isr <= 1'b0;
        tk(2);
        chk(warn_irq, 8'h00);
        warn <= 1'b0;
        tk(6);
        opt <= '0;
        bo_cmp <= 3'h7;
        warn <= 1'b1;
        tk(6);
        chk({warn_irq, oe}, 8'h00);
        rd(2'h0, rv);
        chk(rv & 8'h02, 8'h00);
    endtask : t_warn

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk_i);
        srst_i <= 1'b0;
        rd(2'h0, rv);
        chk(rv & 8'hE9, 8'h00);
        t_brownout();
        t_dog();
        t_warn();
        conclude();
    end
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
endmodule : supply_integrity_reset_flags_bench
